// >>> core/cmpo_top.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module cmpo_top #(
    parameter int NUM_CMP = 2
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    input  wire logic [3:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [7:0]                reg_rdata_o,
    input  wire logic [NUM_CMP-1:0]        compare_raw_i,
    input  wire logic                      sync_timer_clk_i,
    input  wire logic                      sleep_i,
    input  wire logic                      timer_core_clocked_i,
    input  wire logic [NUM_CMP-1:0]        shutdown_source_enable_i,
    output cmpo_pkg::cmpo_fanout_t [NUM_CMP-1:0] fanout_o,
    output logic      [NUM_CMP-1:0]        cmp_out_o,
    output logic                           irq_o,
    output logic                           wake_o
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic [NUM_CMP-1:0] raw_s1_r;
    logic [NUM_CMP-1:0] raw_s2_r;
    logic               tclk_s1_r;
    logic               tclk_s2_r;
    logic               tclk_d_r;

    // Analog comparator result and timer clock are asynchronous to the core.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            raw_s1_r  <= '0;
            raw_s2_r  <= '0;
            tclk_s1_r <= 1'b0;
            tclk_s2_r <= 1'b0;
            tclk_d_r  <= 1'b0;
        end else begin
            raw_s1_r  <= compare_raw_i;
            raw_s2_r  <= raw_s1_r;
            tclk_s1_r <= sync_timer_clk_i;
            tclk_s2_r <= tclk_s1_r;
            tclk_d_r  <= tclk_s2_r;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]         ctrl_r [NUM_CMP];
    logic [NUM_CMP-1:0] irq_stat_r;
    logic [NUM_CMP-1:0] irq_mask_r;
    logic [7:0]         sel_r;

    function automatic logic [7:0] ctrl_view(input logic [7:0] c, input logic o);
        logic [7:0] v;
        v = (c & cmpo_pkg::CTRL_WMASK) | cmpo_pkg::CTRL_FIXED_ONES;
        v[cmpo_pkg::OUT_BIT] = o;
        return v;
    endfunction

    // Writable fields only; status and fixed bits never store.
    // reset all zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                ctrl_r[i] <= cmpo_pkg::CTRL_RESET;
            end
            irq_mask_r <= '0;
            sel_r      <= 8'h00;
        end else if (reg_wr_i) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                if (reg_addr_i == cmpo_pkg::CTRL0_ADDR + 4'(i)) begin
                    ctrl_r[i] <= reg_wdata_i & cmpo_pkg::CTRL_WMASK;
                end
            end
            if (reg_addr_i == cmpo_pkg::IRQ_MASK_ADDR) begin
                irq_mask_r <= reg_wdata_i[NUM_CMP-1:0];
            end
            if (reg_addr_i == cmpo_pkg::SEL_ADDR) begin
                sel_r <= reg_wdata_i & cmpo_pkg::SEL_WMASK;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Comparator output path
    // ------------------------------------------------------------------------
    logic [NUM_CMP-1:0] adj_nxt;
    logic [NUM_CMP-1:0] adj_r;
    logic [NUM_CMP-1:0] sync_q_r;
    logic [NUM_CMP-1:0] out_nxt;
    logic [NUM_CMP-1:0] out_r;
    cmpo_pkg::cmpo_sync_t sync_st_r;
    logic               tclk_fall;

    assign tclk_fall = tclk_d_r & ~tclk_s2_r;

    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            adj_nxt[i] = ctrl_r[i][cmpo_pkg::ENABLE_BIT] &
                         (raw_s2_r[i] ^ ctrl_r[i][cmpo_pkg::INVERT_BIT]);
        end
    end

    // A core-clocked timer halts in sleep, so the capture stage holds.
    // sleep freezes sync
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_st_r <= cmpo_pkg::SYNC_TRACK;
        end else begin
            case (sync_st_r)
                cmpo_pkg::SYNC_TRACK: begin
                    if (sleep_i && timer_core_clocked_i) begin
                        sync_st_r <= cmpo_pkg::SYNC_HOLD;
                    end
                end
                cmpo_pkg::SYNC_HOLD: begin
                    if (!(sleep_i && timer_core_clocked_i)) begin
                        sync_st_r <= cmpo_pkg::SYNC_TRACK;
                    end
                end
                default: sync_st_r <= cmpo_pkg::SYNC_TRACK;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_q_r <= '0;
        end else if (tclk_fall && sync_st_r == cmpo_pkg::SYNC_TRACK) begin
            sync_q_r <= adj_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            out_nxt[i] = ctrl_r[i][cmpo_pkg::SYNC_BIT] ? sync_q_r[i] : adj_nxt[i];
        end
    end

    // Status follows the live adjusted result; the pin path may be synced.
    // status bit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            adj_r <= '0;
            out_r <= '0;
        end else begin
            adj_r <= adj_nxt;
            out_r <= out_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Consumer fan-out
    // ------------------------------------------------------------------------
    // independent instances
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            fanout_o  <= '0;
            cmp_out_o <= '0;
        end else begin
            for (int i = 0; i < NUM_CMP; i++) begin
                fanout_o[i].shutdown    <= out_nxt[i] & shutdown_source_enable_i[i] &
                                           sel_r[cmpo_pkg::SEL_SHDN_LSB + i];
                fanout_o[i].adc_trigger <= out_nxt[i] & ~out_r[i] &
                                           sel_r[cmpo_pkg::SEL_ADC_LSB + i];
                fanout_o[i].timer_reset <= out_nxt[i] & ~out_r[i] &
                                           sel_r[cmpo_pkg::SEL_TMR_LSB + i];
            end
            cmp_out_o <= out_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    logic stat_rd;

    assign stat_rd = reg_rd_i && reg_addr_i == cmpo_pkg::IRQ_STAT_ADDR;

    // A new change in the reading cycle wins over the read clear.
    // sticky change flag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | (adj_nxt ^ adj_r);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= |(irq_stat_r & irq_mask_r);
            wake_o <= sleep_i & |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Unmapped addresses read zero.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= 8'h00;
            for (int i = 0; i < NUM_CMP; i++) begin
                if (reg_addr_i == cmpo_pkg::CTRL0_ADDR + 4'(i)) begin
                    reg_rdata_o <= ctrl_view(ctrl_r[i], adj_r[i]);
                end
            end
            if (reg_addr_i == cmpo_pkg::IRQ_STAT_ADDR) begin
                reg_rdata_o <= 8'(irq_stat_r);
            end
            if (reg_addr_i == cmpo_pkg::IRQ_MASK_ADDR) begin
                reg_rdata_o <= 8'(irq_mask_r);
            end
            if (reg_addr_i == cmpo_pkg::SEL_ADDR) begin
                reg_rdata_o <= sel_r;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule // cmpo_top

`default_nettype wire

// >>> core/cmpo_pkg.sv
package cmpo_pkg;

    // ------------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  CTRL0_ADDR      = 4'h0;  // Control of instance 0.
    localparam logic [3:0]  CTRL1_ADDR      = 4'h1;  // Control of instance 1.
    localparam logic [3:0]  IRQ_STAT_ADDR   = 4'h2;  // Sticky events, clear on read.
    localparam logic [3:0]  IRQ_MASK_ADDR   = 4'h3;  // Interrupt enable mask.
    localparam logic [3:0]  SEL_ADDR        = 4'h4;  // Consumer routing selects.

    // ------------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------------
    localparam int          ENABLE_BIT      = 7;
    localparam int          OUT_BIT         = 6;
    localparam int          INVERT_BIT      = 4;
    localparam int          ONE_BIT         = 2;
    localparam int          DEADBAND_BIT    = 1;
    localparam int          SYNC_BIT        = 0;
    localparam logic [7:0]  CTRL_WMASK      = 8'h93;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  CTRL_FIXED_ONES = 8'h04;

    // ------------------------------------------------------------------------
    // Routing select fields (one bit per instance, per consumer)
    // ------------------------------------------------------------------------
    localparam int          SEL_ADC_LSB     = 0;
    localparam int          SEL_TMR_LSB     = 2;
    localparam int          SEL_SHDN_LSB    = 4;
    localparam logic [7:0]  SEL_WMASK       = 8'h3f;

    // Per-instance fan-out toward the consumers.
    typedef struct packed {
        logic adc_trigger;
        logic timer_reset;
        logic shutdown;
    } cmpo_fanout_t;

    // State of the sync-timer falling-edge capture.
    typedef enum logic [1:0] {
        SYNC_HOLD  = 2'b01,
        SYNC_TRACK = 2'b10
    } cmpo_sync_t;

endpackage : cmpo_pkg

// >>> tb/cmpo_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the comparator output block, instance 0 stands for both.
module cmpo_chk #(
    parameter int NUM_CMP = 2
) (
    input wire logic                             core_clk_i,
    input wire logic                             rst_i,
    input wire logic [3:0]                       reg_addr_i,
    input wire logic                             reg_rd_i,
    input wire logic [7:0]                       reg_rdata_o,
    input wire logic                             sleep_i,
    input wire cmpo_pkg::cmpo_fanout_t [NUM_CMP-1:0] fanout_o,
    input wire logic [NUM_CMP-1:0]               cmp_out_o,
    input wire logic                             irq_o,
    input wire logic                             wake_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // A control read is the strobe, then its data one cycle later.
    sequence s_ctl_rd;
        reg_rd_i && reg_addr_i[3:1] == 3'h0 ##1 1'b1;
    endsequence
    property p_ctl_bits;
        s_ctl_rd |-> !reg_rdata_o[5] && !reg_rdata_o[3] && reg_rdata_o[2];
    endproperty
    a_ctl_bits: assert property (p_ctl_bits) else $error("control fixed bits wrong");
    property p_rd_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_trig_pulse;
        fanout_o[0].adc_trigger |=> !fanout_o[0].adc_trigger;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("conversion start too long");
    property p_trig_high;
        fanout_o[0].adc_trigger |-> cmp_out_o[0];
    endproperty
    a_trig_high: assert property (p_trig_high) else $error("conversion start on low output");
    property p_trst_pulse;
        fanout_o[0].timer_reset |=> !fanout_o[0].timer_reset;
    endproperty
    a_trst_pulse: assert property (p_trst_pulse) else $error("timer restart too long");
    property p_shdn;
        !cmp_out_o[0] [*2] |-> !fanout_o[0].shutdown;
    endproperty
    a_shdn: assert property (p_shdn) else $error("shutdown while output low");
    // Wake is registered, so it answers to the sleep level of the cycle before.
    property p_wake;
        wake_o |-> irq_o && $past(sleep_i);
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside sleep");
    property p_reset;
        disable iff (1'b0) rst_i |=> cmp_out_o == '0 && !irq_o && !wake_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule // cmpo_chk
bind cmpo_top cmpo_chk #(.NUM_CMP(NUM_CMP)) cmpo_chk_inst (.core_clk_i, .rst_i,
    .reg_addr_i, .reg_rd_i, .reg_rdata_o, .sleep_i, .fanout_o, .cmp_out_o, .irq_o, .wake_o);
`default_nettype wire

// >>> tb/cmpo_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the sync timer and the conversion and restart consumers.
module cmpo_far_model (
    input  wire logic                       core_clk_i,
    input  wire cmpo_pkg::cmpo_fanout_t [1:0] fanout_i,
    output var  logic                       tmr_clk_o
);
    int adc_cnt = 0;
    int trst_cnt = 0;
    // The timer clock idles high so no edge appears unless asked for.
    initial tmr_clk_o = 1'b1;
    // Counts conversion starts and timer restarts from instance 0.
    always @(posedge core_clk_i) begin
        adc_cnt <= adc_cnt + int'(fanout_i[0].adc_trigger);
        trst_cnt <= trst_cnt + int'(fanout_i[0].timer_reset);
    end
    // One slow timer period, long enough for the core to see the falling edge.
    task automatic tick();
        @(posedge core_clk_i) tmr_clk_o <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        tmr_clk_o <= 1'b1;
    endtask
endmodule // cmpo_far_model
`default_nettype wire

// >>> tb/cmpo_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cmpo_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [1:0] raw = 2'b00;
    logic       slp = 1'b0;
    logic       core_ck = 1'b0;
    logic [1:0] sse = 2'b00;
    logic [7:0] rdata, rv, w0, w1, e0, e1;
    logic [1:0] cout;
    logic       irq, wake, tclk;
    cmpo_pkg::cmpo_fanout_t [1:0] fan;
    int         err_total = 0;
    int         samples_checked = 0;
    int         n0, n1;
    cmpo_top cmpo_top_inst (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .compare_raw_i(raw), .sync_timer_clk_i(tclk), .sleep_i(slp),
        .timer_core_clocked_i(core_ck), .shutdown_source_enable_i(sse), .fanout_o(fan),
        .cmp_out_o(cout), .irq_o(irq), .wake_o(wake));
    cmpo_far_model cmpo_far_model_inst (.core_clk_i(clk), .fanout_i(fan), .tmr_clk_o(tclk));
    // A 50 MHz core clock.
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so take them there.
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    // Control value: stored bits, bit 2 set, and the gated, polarity-adjusted status.
    function automatic logic [7:0] exp_ctl(input logic [7:0] w, input logic r);
        return (w & 8'h93) | 8'h04 | {1'b0, w[7] & (r ^ w[4]), 6'h00};
    endfunction
    task automatic results();
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #100000;
        err_total++;
        results();
    end
    // Main sequence: reset values, random setups, fan-out, interrupt, sync mode.
    initial begin
        void'($urandom(41));
        wait_n(4);
        rst <= 1'b0;
        rd_reg(4'h0); chk(rv, 8'h04);
        rd_reg(4'h1); chk(rv, 8'h04);
        rd_reg(4'h7); chk(rv, 8'h00);
        for (int i = 0; i < 40; i++) begin
            w0 = (i == 0) ? 8'h10 : 8'($urandom()) & 8'hfe;
            w1 = 8'($urandom()) & 8'hfe;
            wr_reg(4'h0, w0);
            wr_reg(4'h1, w1);
            raw <= 2'($urandom());
            wait_n(5);
            e0 = exp_ctl(w0, raw[0]);
            e1 = exp_ctl(w1, raw[1]);
            rd_reg(4'h0); chk(rv, e0);
            rd_reg(4'h1); chk(rv, e1);
            chk({6'h00, cout}, {6'h00, e1[6], e0[6]});
            chk({7'h00, irq}, 8'h00);
        end
        wr_reg(4'h0, 8'h80);
        raw <= 2'b00;
        wr_reg(4'h4, 8'h3f);
        rd_reg(4'h4); chk(rv, 8'h3f);
        sse <= 2'b01;
        wait_n(6);
        n0 = cmpo_far_model_inst.adc_cnt;
        n1 = cmpo_far_model_inst.trst_cnt;
        chk({7'h00, fan[0].shutdown}, 8'h00);
        raw <= 2'b01;
        wait_n(6);
        chk(8'(cmpo_far_model_inst.adc_cnt - n0), 8'h01);
        chk(8'(cmpo_far_model_inst.trst_cnt - n1), 8'h01);
        chk({7'h00, fan[0].shutdown}, 8'h01);
        rd_reg(4'h2);
        wr_reg(4'h3, 8'h01);
        rd_reg(4'h3); chk(rv, 8'h01);
        raw <= 2'b00;
        wait_n(6);
        slp <= 1'b1;
        wait_n(2);
        chk({6'h00, wake, irq}, 8'h03);
        rd_reg(4'h2); chk(rv, 8'h01);
        wait_n(2);
        chk({6'h00, wake, irq}, 8'h00);
        slp <= 1'b0;
        wr_reg(4'h0, 8'h81);
        raw <= 2'b01;
        wait_n(4);
        cmpo_far_model_inst.tick();
        wait_n(6);
        chk({7'h00, cout[0]}, 8'h01);
        raw <= 2'b00;
        wait_n(8);
        chk({7'h00, cout[0]}, 8'h01);
        cmpo_far_model_inst.tick();
        wait_n(6);
        chk({7'h00, cout[0]}, 8'h00);
        slp <= 1'b1;
        core_ck <= 1'b1;
        raw <= 2'b01;
        wait_n(4);
        cmpo_far_model_inst.tick();
        wait_n(6);
        chk({7'h00, cout[0]}, 8'h00);
        core_ck <= 1'b0;
        cmpo_far_model_inst.tick();
        wait_n(6);
        chk({7'h00, cout[0]}, 8'h01);
        results();
    end
endmodule // cmpo_tb_top
`default_nettype wire
